// [core/wdr_params.svh]
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDR_PARAMS_SVH
`define WDR_PARAMS_SVH

`define WDR_ADDR_W 8
`define WDR_CTRL_OFFSET 8'hD2
`define WDR_BIT_STOP_UNLOCK 4
`define WDR_BIT_ON 3
`define WDR_BIT_KICK 2
`define WDR_PRE_LSB 0
`define WDR_PRE_RESET 2'h3
`define WDR_ON_RESET 1'b1
`define WDR_STOP_UNLOCK_RESET 1'b0
`define WDR_PRE_BASE_LOG2 11
`define WDR_UNLOCK_WINDOW 16
`define WDR_RESET_PULSE 4

`endif

// [core/wdr_pkg.sv]
// Types shared by the watchdog reset timer
package wdr_pkg;

	typedef struct packed {
		logic [1:0] pre;
		logic on;
		logic stop_unlock;
		logic [4:0] unlock_cnt;
		logic [13:0] div_cnt;
		logic [7:0] wd_cnt;
		logic [2:0] rst_cnt;
		logic sys_reset;
		logic [7:0] rdata;
		logic pd_meta;
		logic pd_sync;
	} wdr_state_t;

endpackage

// [core/wdr_watchdog.sv]
// Watchdog reset timer with its control register
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "wdr_params.svh"

// How it works
// - Prescaled 8-bit counter; overflow asserts system reset
// - Select picks divide by 2048/4096/8192/16384
// - Timeout is 256 times 2^(11+select) cycles
// - Reset: on=1, select=11, unlock=0
// - Kick clears count; kick reads zero
// - Disable only within 16 cycles of unlock
// - Writing on bit set enables directly
// - No counting while in power-down
module wdr_watchdog (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	input wire logic power_down,
	output logic sys_reset_out
);

	wdr_pkg::wdr_state_t st_ff;
	wdr_pkg::wdr_state_t nxt_st;

	logic ctrl_wr;
	logic kick;
	logic [13:0] div_last;
	logic div_tick;

	assign ctrl_wr = wr_stb && (addr == `WDR_CTRL_OFFSET);
	assign kick = ctrl_wr && wdata[`WDR_BIT_KICK];

	// Terminal count is 2^(11+select)-1; low bits of the divider reach it together
	always_comb begin
		div_last = 14'h0000;
		unique case (st_ff.pre)
			2'h0: div_last = 14'h07FF;
			2'h1: div_last = 14'h0FFF;
			2'h2: div_last = 14'h1FFF;
			2'h3: div_last = 14'h3FFF;
		endcase
	end

	assign div_tick = (st_ff.div_cnt == div_last);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pd_meta = power_down;
		nxt_st.pd_sync = st_ff.pd_meta;

		// Unlock window counts down from the cycle the unlock bit is written from clear to set
		if (st_ff.unlock_cnt != 5'h00) begin
			nxt_st.unlock_cnt = st_ff.unlock_cnt - 5'h01;
		end

		if (ctrl_wr) begin
			nxt_st.pre = wdata[`WDR_PRE_LSB +: 2];
			nxt_st.stop_unlock = wdata[`WDR_BIT_STOP_UNLOCK];
			if (wdata[`WDR_BIT_STOP_UNLOCK] && !st_ff.stop_unlock) begin
				nxt_st.unlock_cnt = 5'(`WDR_UNLOCK_WINDOW);
			end
			if (wdata[`WDR_BIT_ON]) begin
				nxt_st.on = 1'b1;
			end else if (st_ff.unlock_cnt != 5'h00) begin
				nxt_st.on = 1'b0;
				nxt_st.unlock_cnt = 5'h00;
			end
		end

		// Counting: idle when off, in power-down, or while reset is being driven
		if (kick || !st_ff.on) begin
			nxt_st.div_cnt = 14'h0000;
			nxt_st.wd_cnt = 8'h00;
		end else if (!st_ff.pd_sync && !st_ff.sys_reset) begin
			if (div_tick) begin
				nxt_st.div_cnt = 14'h0000;
				nxt_st.wd_cnt = st_ff.wd_cnt + 8'h01;
				if (st_ff.wd_cnt == 8'hFF) begin
					nxt_st.sys_reset = 1'b1;
					nxt_st.rst_cnt = 3'(`WDR_RESET_PULSE);
				end
			end else begin
				nxt_st.div_cnt = st_ff.div_cnt + 14'h0001;
			end
		end

		// The reset pulse also returns the control register to its reset state,
		// since the watchdog lives inside the system it resets
		if (st_ff.sys_reset) begin
			nxt_st.pre = `WDR_PRE_RESET;
			nxt_st.on = `WDR_ON_RESET;
			nxt_st.stop_unlock = `WDR_STOP_UNLOCK_RESET;
			nxt_st.unlock_cnt = 5'h00;
			nxt_st.div_cnt = 14'h0000;
			nxt_st.wd_cnt = 8'h00;
			if (st_ff.rst_cnt == 3'h1) begin
				nxt_st.sys_reset = 1'b0;
			end
			nxt_st.rst_cnt = st_ff.rst_cnt - 3'h1;
		end

		nxt_st.rdata = 8'h00;
		if (rd_stb && (addr == `WDR_CTRL_OFFSET)) begin
			nxt_st.rdata[`WDR_BIT_STOP_UNLOCK] = st_ff.stop_unlock;
			nxt_st.rdata[`WDR_BIT_ON] = st_ff.on;
			nxt_st.rdata[`WDR_BIT_KICK] = 1'b0;
			nxt_st.rdata[`WDR_PRE_LSB +: 2] = st_ff.pre;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.pre <= `WDR_PRE_RESET;
			st_ff.on <= `WDR_ON_RESET;
			st_ff.stop_unlock <= `WDR_STOP_UNLOCK_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rdata = st_ff.rdata;
	assign sys_reset_out = st_ff.sys_reset;

endmodule

// [test/wdr_assertions.sv]
// Port checker for the watchdog reset timer
`timescale 1ns/1ps
module wdr_chk (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic power_down,
	input wire logic sys_reset_out,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	wire r = addr == 8'hD2, w = wr_stb && r, s = sys_reset_out;
	chk_idle_zero: assert property (!$past(rd_stb) |-> !rdata) else $error("idle");
	chk_kick_zero: assert property (rd_stb |=> !rdata[2]) else $error("kick");
	chk_resv_zero: assert property (rd_stb |=> !rdata[7:5]) else $error("resv");
	chk_map_zero: assert property (rd_stb && !r |=> !rdata) else $error("map");
	chk_pulse_width: assert property ($rose(s) |-> s [*4] ##1 !s) else $error("width");
	chk_kick_quiet: assert property (w && wdata[2] && !s |=> ##1 !s [*8]) else $error("kq");
	chk_pd_freeze: assert property (power_down [*6] |-> !$rose(s)) else $error("pd");
	chk_write_back: assert property (w && wdata[3] ##2 rd_stb && r && !s |=> rdata[4:0] ==
		($past(wdata[4:0], 3) & 5'h1B)) else $error("wb");
	cover property ($rose(s));
	cover property (w && !wdata[3]);
	cover property (power_down [*6]);
endmodule
bind wdr_watchdog wdr_chk u_chk (.mclk, .reset, .wr_stb, .rd_stb, .power_down, .sys_reset_out,
	.addr, .wdata, .rdata);

// [test/watchdog_reset_timer_bench.sv]
// Bench for the watchdog reset timer
`timescale 1ns/1ps
module watchdog_reset_timer_bench;
	logic mclk = 0, reset = 1, wr_stb = 0, rd_stb = 0, power_down = 0, sys_reset_out;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, m = 8'h0B;
	int errors = 0, check_count = 0, n = $urandom(32'h9D24), t = 0;
	always #5 mclk = ~mclk;
	wdr_watchdog u_wdr_watchdog (.mclk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
		.power_down, .sys_reset_out);
	task cmp(input logic [7:0] e, g);
		check_count++;
		errors += g !== e;
		if (g !== e) $display("MISMATCH %0t %h %h", $time, e, g);
	endtask
	task cmp_cycles(input int e, g);
		check_count++;
		errors += (g != e);
		if (g != e) $display("MISMATCH %0t %h %h", $time, e, g);
	endtask
	task bus(input logic w, input logic [7:0] a, d);
		@(posedge mclk) {wr_stb, rd_stb, addr, wdata} <= {w, !w, a, d};
		@(posedge mclk) {wr_stb, rd_stb} <= 2'h0;
	endtask
	// Model: a clear of the on bit needs an unlock rise less than 17 cycles before
	task wr(input logic [7:0] d);
		bus(1, 8'hD2, d);
		n = !d[3] && $time - t < 170;
		t = d[4] && !m[4] ? int'($time) : n ? 0 : t;
		m = {3'h0, d[4], d[3] || m[3] && !n, 1'b0, d[1:0]};
	endtask
	task conclude(input int e);
		errors += e;
		$display("%0d checks %0d errors", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial #6000000 conclude(1);
	initial begin
		repeat (12) @(posedge mclk);
		reset <= 0;
		for (int i = 0; i < 10; i++) begin
			bus(0, i[0] ? 8'h40 : 8'hD2, 8'h00);
			#1 cmp(i[0] ? 8'h00 : m, rdata);
			wr({6'($urandom), 2'(i / 2)} | 8'h08);
		end
		// Late clear is refused, prompt clear is taken
		for (int g = 20; g >= 0; g -= 20) begin
			wr(8'h0B);
			wr(8'h1B);
			repeat (g) @(posedge mclk);
			wr(8'h13);
			bus(0, 8'hD2, 8'h00);
			#1 cmp(m, rdata);
		end
		$display("regs done");
		wr(8'h0C);
		n = int'($time);
		@(posedge mclk) power_down <= 1;
		repeat (3000) @(posedge mclk);
		power_down <= 0;
		// Single fast clock here, so the watchdog is left on
		while (!sys_reset_out && $time - n < 6000000) @(posedge mclk) #1;
		cmp_cycles(256 * (1 << 11) + 3000, int'(($time - n - 1) / 10));
		repeat (6) @(posedge mclk);
		bus(0, 8'hD2, 8'h00);
		#1 cmp(8'h0B, rdata);
		$display("timeout done");
		conclude(0);
	end
endmodule
